// ---- src/hsr_cfg.svh ----
`ifndef HSR_CFG_SVH
`define HSR_CFG_SVH
// register offsets
`define HSR_OFS_CH12_LIMIT 8'h03
`define HSR_OFS_CH12_FAULT 8'h04
`define HSR_OFS_LATCH_CHAN 8'h07
`define HSR_OFS_LATCH_OC 8'h08
`define HSR_OFS_FET_STATUS 8'h09
// reset values
`define HSR_RST_CH12_LIMIT 8'hbf
`define HSR_RST_CH12_FAULT 8'h01
// field positions
`define HSR_BIT_PG_LOST 4
`define HSR_BIT_TIMEOUT 5
`define HSR_BIT_LO_PG_LOST 6
`define HSR_BIT_LO_TIMEOUT 7
`define HSR_BIT_OC 4
`define HSR_BIT_FTR 5
`define HSR_BIT_LO_OC 6
`define HSR_BIT_LO_FTR 7
`define HSR_BIT_BLOCK 3
`define HSR_BIT_PASS 4
`define HSR_BIT_REVERSE 5
`define HSR_BIT_LO_GATE 7
`define HSR_BIT_HP 6
`define HSR_BIT_ORING 7
`define HSR_BIT_EN 5
`define HSR_BIT_UV 6
`define HSR_BIT_DS 7
// timing: fault time unit 0.45 ms = 450000 ns, clock period 5 ns
`define HSR_FT_UNIT_NS 450000
`define HSR_CLK_NS 5
`define HSR_FT_UNIT_CYC (`HSR_FT_UNIT_NS / `HSR_CLK_NS)
`endif

// ---- src/hsr_pkg.sv ----
package hsr_pkg;
	typedef logic [7:0] hsr_byte_t;
	typedef enum logic [1:0] {
		HSR_OFF,
		HSR_WAIT_DISCHARGE,
		HSR_ON
	} hsr_state_t;
endpackage

// ---- src/hsr_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "hsr_cfg.svh"
// Contract
// - hi rail power-good loss sets latch bit 4, held until read
// - hi rail fault timer expiry sets latch bit 5
// - lo rail power-good loss sets latch bit 6
// - lo rail fault timer expiry sets latch bit 7
// - channel latch register read-only, cleared after a read
// - overcurrent latch register read-only, cleared after a read
// - hi rail current limiting sets overcurrent bit 4
// - hi rail fast trip sets overcurrent bit 5
// - lo rail current limiting sets overcurrent bit 6
// - lo rail fast trip sets overcurrent bit 7
// - fet status live; bit 4 pass gate, bit 5 reverse state
// - fet status bit 3 high while blocking gate commanded high
// - fet status bit 7 high when lo rail gate driven on
// - limit code all ones is maximum, all zeros is quarter
// - cleared limit bits lower by 5, 10, 20, 40 percent
// - power-good code 11 selects highest, 00 lowest threshold
// - high-power bit moves oring turn-off threshold positive
// - oring allow cleared holds blocking gate low
// - fault time equals code times 0.45 ms; code 0 never times out
// - master enable cleared drives pass and blocking gates low
// - discharged-start waits for output below bleed threshold
// - bleed connect cleared disconnects discharge path
// - hi rail power-good latch also set at each turn-on
module hsr_regs (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// register access from the serial engine
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire hsr_pkg::hsr_byte_t i_addr,
	input wire hsr_pkg::hsr_byte_t i_wdata,
	output var hsr_pkg::hsr_byte_t o_rdata,
	output logic o_rvalid,
	// analog comparator levels
	input wire logic i_hi_rail_output_above_pg,
	input wire logic i_lo_rail_output_above_pg,
	input wire logic i_lo_rail_timeout,
	input wire logic i_hi_rail_in_limit,
	input wire logic i_hi_rail_fasttrip,
	input wire logic i_lo_rail_in_limit,
	input wire logic i_lo_rail_fasttrip,
	input wire logic i_hi_rail_pass_gate_state,
	input wire logic i_lo_rail_reverse_state,
	input wire logic i_lo_rail_gate_state,
	input wire logic i_hi_rail_output_discharged,
	input wire logic i_hi_rail_oring_on_req,
	// analog controls
	output var logic [3:0] o_hi_rail_limit_code,
	output var logic [1:0] o_hi_rail_pgood_code,
	output logic o_hi_rail_oring_high_power,
	output logic o_blocking_gate_out,
	output logic o_hi_rail_pass_gate_on,
	output logic o_hi_rail_bleed_connect
);
	import hsr_pkg::*;

	// ************************************************
	// configuration registers
	// ************************************************
	hsr_byte_t limit_cfg_ff;
	hsr_byte_t fault_cfg_ff;
	hsr_byte_t chan_latch_ff;
	hsr_byte_t oc_latch_ff;
	hsr_state_t state_ff;
	logic [4:0] ft_units_ff;
	logic [31:0] ft_cyc_ff;
	logic pg_prev_ff;
	logic tripped_ff; // timed out; held off until enable is cycled
	logic turn_on_pulse;
	logic hi_timeout;
	logic rd_chan;
	logic rd_oc;
	hsr_byte_t fet_live;
	hsr_byte_t chan_set;
	hsr_byte_t oc_set;

	assign rd_chan = i_rd_stb && (i_addr == `HSR_OFS_LATCH_CHAN);
	assign rd_oc = i_rd_stb && (i_addr == `HSR_OFS_LATCH_OC);

	// host writes; latch and status registers ignore writes
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			limit_cfg_ff <= `HSR_RST_CH12_LIMIT;
			fault_cfg_ff <= `HSR_RST_CH12_FAULT;
		end else if (i_wr_stb) begin
			if (i_addr == `HSR_OFS_CH12_LIMIT) begin
				limit_cfg_ff <= i_wdata;
			end else if (i_addr == `HSR_OFS_CH12_FAULT) begin
				fault_cfg_ff <= i_wdata;
			end
		end
	end

	// ************************************************
	// hi rail channel control
	// ************************************************
	// on/off sequencing; discharged-start gates entry to on
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			state_ff <= HSR_OFF;
		end else begin
			case (state_ff)
				HSR_OFF: begin
					if (fault_cfg_ff[`HSR_BIT_EN] && !tripped_ff && !hi_timeout) begin
						if (fault_cfg_ff[`HSR_BIT_UV] && !i_hi_rail_output_discharged) begin
							state_ff <= HSR_WAIT_DISCHARGE;
						end else begin
							state_ff <= HSR_ON;
						end
					end
				end
				HSR_WAIT_DISCHARGE: begin
					if (!fault_cfg_ff[`HSR_BIT_EN]) begin
						state_ff <= HSR_OFF;
					end else if (i_hi_rail_output_discharged) begin
						state_ff <= HSR_ON;
					end
				end
				HSR_ON: begin
					// timeout latches the channel off until enable is cycled
					if (!fault_cfg_ff[`HSR_BIT_EN] || hi_timeout) begin
						state_ff <= HSR_OFF;
					end
				end
				default: begin
					state_ff <= HSR_OFF;
				end
			endcase
		end
	end

	assign turn_on_pulse = (state_ff != HSR_ON) && fault_cfg_ff[`HSR_BIT_EN] && !tripped_ff &&
		(!fault_cfg_ff[`HSR_BIT_UV] || i_hi_rail_output_discharged);

	// fault timer: runs while limiting, code times the unit
	assign hi_timeout = (state_ff == HSR_ON) && i_hi_rail_in_limit &&
		(ft_units_ff == fault_cfg_ff[4:0]) && (fault_cfg_ff[4:0] != 5'h0_0);
	always_ff @(posedge i_mclk) begin
		if (i_reset || state_ff != HSR_ON || !i_hi_rail_in_limit) begin
			ft_cyc_ff <= 32'h0000_0000;
			ft_units_ff <= 5'h0_0;
		end else if (ft_cyc_ff == 32'(`HSR_FT_UNIT_CYC - 1)) begin
			ft_cyc_ff <= 32'h0000_0000;
			if (ft_units_ff != 5'h1_f) begin
				ft_units_ff <= ft_units_ff + 5'h0_1;
			end
		end else begin
			ft_cyc_ff <= ft_cyc_ff + 32'h0000_0001;
		end
	end

	// analog drive outputs, registered
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_hi_rail_limit_code <= 4'hf;
			o_hi_rail_pgood_code <= 2'h3;
			o_hi_rail_oring_high_power <= 1'b0;
			o_blocking_gate_out <= 1'b0;
			o_hi_rail_pass_gate_on <= 1'b0;
			o_hi_rail_bleed_connect <= 1'b0;
		end else begin
			// code passed as weights; analog side scales 25% to 100%
			o_hi_rail_limit_code <= limit_cfg_ff[3:0];
			o_hi_rail_pgood_code <= limit_cfg_ff[5:4];
			o_hi_rail_oring_high_power <= limit_cfg_ff[`HSR_BIT_HP];
			o_blocking_gate_out <= (state_ff == HSR_ON) && limit_cfg_ff[`HSR_BIT_ORING] &&
				i_hi_rail_oring_on_req;
			o_hi_rail_pass_gate_on <= (state_ff == HSR_ON);
			o_hi_rail_bleed_connect <= fault_cfg_ff[`HSR_BIT_DS];
		end
	end

	// ************************************************
	// latched event registers
	// ************************************************
	always_comb begin
		chan_set = 8'h00;
		chan_set[`HSR_BIT_PG_LOST] = (pg_prev_ff && !i_hi_rail_output_above_pg) ||
			turn_on_pulse;
		chan_set[`HSR_BIT_TIMEOUT] = hi_timeout;
		chan_set[`HSR_BIT_LO_PG_LOST] = 1'b0;
		chan_set[`HSR_BIT_LO_TIMEOUT] = i_lo_rail_timeout;
		oc_set = 8'h00;
		oc_set[`HSR_BIT_OC] = i_hi_rail_in_limit;
		oc_set[`HSR_BIT_FTR] = i_hi_rail_fasttrip;
		oc_set[`HSR_BIT_LO_OC] = i_lo_rail_in_limit;
		oc_set[`HSR_BIT_LO_FTR] = i_lo_rail_fasttrip;
	end

	// lo rail power-good edge memory; timeout trip latch, cleared while enable is low
	logic lo_pg_prev_ff;
	always_ff @(posedge i_mclk) begin
		if (i_reset || !fault_cfg_ff[`HSR_BIT_EN]) begin
			tripped_ff <= 1'b0;
		end else if (hi_timeout) begin
			tripped_ff <= 1'b1;
		end
	end

	// edge memory registers
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			pg_prev_ff <= 1'b0;
			lo_pg_prev_ff <= 1'b0;
		end else begin
			pg_prev_ff <= i_hi_rail_output_above_pg;
			lo_pg_prev_ff <= i_lo_rail_output_above_pg;
		end
	end

	// clear on read; a set in the same cycle wins
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			chan_latch_ff <= 8'h00;
		end else begin
			chan_latch_ff <= ((rd_chan ? 8'h00 : chan_latch_ff) | chan_set |
				{1'b0, lo_pg_prev_ff && !i_lo_rail_output_above_pg, 6'h00}) &
				8'hf0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			oc_latch_ff <= 8'h00;
		end else begin
			oc_latch_ff <= ((rd_oc ? 8'h00 : oc_latch_ff) | oc_set) & 8'hf0;
		end
	end

	// ************************************************
	// read path
	// ************************************************
	// live status, no latching
	always_comb begin
		fet_live = 8'h00;
		fet_live[`HSR_BIT_BLOCK] = o_blocking_gate_out;
		fet_live[`HSR_BIT_PASS] = i_hi_rail_pass_gate_state;
		fet_live[`HSR_BIT_REVERSE] = i_lo_rail_reverse_state;
		fet_live[`HSR_BIT_LO_GATE] = i_lo_rail_gate_state;
	end

	// read data one cycle after strobe; unmapped reads give zero
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd_stb;
			if (!i_rd_stb) begin
				o_rdata <= o_rdata;
			end else if (i_addr == `HSR_OFS_CH12_LIMIT) begin
				o_rdata <= limit_cfg_ff;
			end else if (i_addr == `HSR_OFS_CH12_FAULT) begin
				o_rdata <= fault_cfg_ff;
			end else if (i_addr == `HSR_OFS_LATCH_CHAN) begin
				o_rdata <= chan_latch_ff;
			end else if (i_addr == `HSR_OFS_LATCH_OC) begin
				o_rdata <= oc_latch_ff;
			end else if (i_addr == `HSR_OFS_FET_STATUS) begin
				o_rdata <= fet_live;
			end else begin
				o_rdata <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/hsr_regs_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module hsr_regs_chk (
	// clock, reset, access
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_rd_stb,
	input wire hsr_pkg::hsr_byte_t i_addr,
	input wire hsr_pkg::hsr_byte_t o_rdata,
	// comparator levels
	input wire logic i_hi_rail_output_above_pg,
	input wire logic i_lo_rail_output_above_pg,
	input wire logic i_hi_rail_in_limit,
	input wire logic i_hi_rail_fasttrip,
	input wire logic i_lo_rail_in_limit,
	input wire logic i_hi_rail_pass_gate_state,
	input wire logic i_lo_rail_reverse_state,
	input wire logic i_lo_rail_gate_state,
	input wire logic i_hi_rail_oring_on_req,
	// controls
	input wire logic [3:0] o_hi_rail_limit_code,
	input wire logic [1:0] o_hi_rail_pgood_code,
	input wire logic o_blocking_gate_out
);
	import hsr_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	// latch reads; a quiet cycle before keeps set-wins out of the way
	sequence s_rd7; i_rd_stb && i_addr == 8'h07; endsequence
	sequence s_rd8; i_rd_stb && i_addr == 8'h08; endsequence
	property p_pg; $fell(i_hi_rail_output_above_pg) ##1 !i_rd_stb ##1 s_rd7 |=> o_rdata[4];
	endproperty
	a_pg: assert property (p_pg) else $error("pgood loss lost");
	property p_oc; i_hi_rail_in_limit ##1 !i_rd_stb ##1 s_rd8 |=> o_rdata[4]; endproperty
	a_oc: assert property (p_oc) else $error("limit event lost");
	property p_ftr; i_hi_rail_fasttrip ##1 !i_rd_stb ##1 s_rd8 |=> o_rdata[5]; endproperty
	a_ftr: assert property (p_ftr) else $error("fast trip lost");
	property p_clr;
		(i_rd_stb && i_addr == 8'h07 && i_lo_rail_output_above_pg)[*2] |=> !o_rdata[6];
	endproperty
	a_clr: assert property (p_clr) else $error("latch not cleared");
	property p_keep; (i_lo_rail_in_limit && i_rd_stb && i_addr == 8'h08) ##1 s_rd8 |=> o_rdata[6];
	endproperty
	a_keep: assert property (p_keep) else $error("event lost on read");
	property p_fet; i_rd_stb && i_addr == 8'h09 |=> o_rdata == {$past(i_lo_rail_gate_state),
		1'b0, $past(i_lo_rail_reverse_state), $past(i_hi_rail_pass_gate_state),
		$past(o_blocking_gate_out), 3'h0};
	endproperty
	a_fet: assert property (p_fet) else $error("fet status wrong");
	property p_blk; o_blocking_gate_out |-> $past(i_hi_rail_oring_on_req); endproperty
	a_blk: assert property (p_blk) else $error("gate without request");
	property p_rst; $fell(i_reset) |-> o_hi_rail_limit_code == 4'hf && o_hi_rail_pgood_code == 2'h3;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset code");
endmodule
bind hsr_regs hsr_regs_chk u_hsr_regs_chk (.i_mclk, .i_reset, .i_rd_stb, .i_addr, .o_rdata,
	.i_hi_rail_output_above_pg, .i_lo_rail_output_above_pg, .i_hi_rail_in_limit,
	.i_hi_rail_fasttrip, .i_lo_rail_in_limit, .i_hi_rail_pass_gate_state,
	.i_lo_rail_reverse_state, .i_lo_rail_gate_state, .i_hi_rail_oring_on_req,
	.o_hi_rail_limit_code, .o_hi_rail_pgood_code, .o_blocking_gate_out);
`default_nettype wire

// ---- verif/hsr_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module hsr_host (
	// clock and answer
	input wire logic i_mclk,
	input wire hsr_pkg::hsr_byte_t i_rdata,
	input wire logic i_rvalid,
	// requests
	output logic o_wr_stb,
	output logic o_rd_stb,
	output hsr_pkg::hsr_byte_t o_addr,
	output hsr_pkg::hsr_byte_t o_wdata
);
	import hsr_pkg::*;
	// idle lines flip so a stale value is never mistaken for data
	initial begin
		{o_wr_stb, o_rd_stb, o_addr, o_wdata} = '0;
	end
	task automatic wr(input hsr_byte_t a, input hsr_byte_t d);
		if (a == 8'h04 && d[4:0] == 5'h00) begin
			d[4:0] = 5'h01;
		end
		@(negedge i_mclk);
		{o_wr_stb, o_addr, o_wdata} = {1'b1, a, d};
		@(negedge i_mclk);
		{o_wr_stb, o_addr, o_wdata} = {1'b0, ~a, ~d};
	endtask
	// answer stands one cycle, taken before release
	task automatic rd(input hsr_byte_t a, output hsr_byte_t d);
		@(negedge i_mclk);
		{o_rd_stb, o_addr} = {1'b1, a};
		@(negedge i_mclk);
		d = i_rvalid ? i_rdata : 8'hxx;
		{o_rd_stb, o_addr} = {1'b0, ~a};
	endtask
endmodule
`default_nettype wire

// ---- verif/hot_swap_status_config_regs_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
	$display("wrong value at %0t: %h not %h", $time, a, e); end end
module hot_swap_status_config_regs_bench;
	import hsr_pkg::*;
	logic clk, rst, ws, rs, rv, ps, rvs, gs, dis, req, flt, blocking_gate_out, on, hp, bl;
	hsr_byte_t ad, wd, rdt, rd;
	logic [6:0] ev;
	logic [3:0] lim;
	logic [1:0] pg;
	int err_count, n_tests, i;
	// register and bit hit by each event line
	hsr_byte_t ev_reg[7] = '{8'h07, 8'h07, 8'h07, 8'h08, 8'h08, 8'h08, 8'h08};
	hsr_byte_t ev_bit[7] = '{8'h10, 8'h40, 8'h80, 8'h10, 8'h20, 8'h40, 8'h80};
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	hsr_host u_hsr_host (.i_mclk(clk), .i_rdata(rdt), .i_rvalid(rv), .o_wr_stb(ws),
		.o_rd_stb(rs), .o_addr(ad), .o_wdata(wd));
	hsr_regs u_hsr_regs (.i_mclk(clk), .i_reset(rst), .i_wr_stb(ws), .i_rd_stb(rs),
		.i_addr(ad), .i_wdata(wd), .o_rdata(rdt), .o_rvalid(rv),
		.i_hi_rail_output_above_pg(~ev[0]), .i_lo_rail_output_above_pg(~ev[1]),
		.i_lo_rail_timeout(ev[2]), .i_hi_rail_in_limit(ev[3] | flt),
		.i_hi_rail_fasttrip(ev[4]), .i_lo_rail_in_limit(ev[5]), .i_lo_rail_fasttrip(ev[6]),
		.i_hi_rail_pass_gate_state(ps), .i_lo_rail_reverse_state(rvs),
		.i_lo_rail_gate_state(gs), .i_hi_rail_output_discharged(dis),
		.i_hi_rail_oring_on_req(req), .o_hi_rail_limit_code(lim), .o_hi_rail_pgood_code(pg),
		.o_hi_rail_oring_high_power(hp), .o_blocking_gate_out(blocking_gate_out),
		.o_hi_rail_pass_gate_on(on), .o_hi_rail_bleed_connect(bl));
	// masked read and compare
	task automatic rchk(input hsr_byte_t a, input hsr_byte_t e, input hsr_byte_t m);
		u_hsr_host.rd(a, rd);
		`CHK(rd & m, e)
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic complete_run;
		$display("%0d checks, %0d wrong", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		{rst, ev, ps, rvs, gs, dis, req, flt} = {1'b1, 13'h0000};
		cyc(6);
		rst = 1'b0;
		rchk(8'h03, 8'hbf, 8'hff);
		rchk(8'h04, 8'h01, 8'hff);
		u_hsr_host.wr(8'h08, 8'hff);
		rchk(8'h08, 8'h00, 8'hff);
		u_hsr_host.wr(8'h03, 8'h40);
		cyc(3);
		`CHK(lim, 4'h0)
		`CHK(pg, 2'h0)
		`CHK(hp, 1'b1)
		$display("config done");
		// each event pulse once, then two reads: set, then cleared
		for (i = 0; i < 7; i++) begin
			ev = 7'h01 << i;
			cyc(1);
			ev = '0;
			cyc(2);
			rchk(ev_reg[i], ev_bit[i], ev_bit[i]);
			rchk(ev_reg[i], 8'h00, ev_bit[i]);
		end
		ev = 7'h20;
		rchk(8'h08, 8'h40, 8'h40);
		ev = '0;
		rchk(8'h08, 8'h40, 8'h40);
		rchk(8'h08, 8'h00, 8'h40);
		$display("events done");
		u_hsr_host.wr(8'h04, 8'ha1);
		req = 1'b1;
		cyc(4);
		`CHK({on, bl, blocking_gate_out}, 3'h6)
		rchk(8'h07, 8'h10, 8'h10);
		u_hsr_host.wr(8'h03, 8'hff);
		cyc(3);
		{ps, rvs, gs} = 3'h5;
		rchk(8'h09, 8'h98, 8'hff);
		u_hsr_host.wr(8'h04, 8'h81);
		cyc(3);
		`CHK({on, blocking_gate_out}, 2'h0)
		$display("enable done");
		u_hsr_host.wr(8'h04, 8'h61);
		cyc(8);
		`CHK(on, 1'b0)
		dis = 1'b1;
		cyc(4);
		`CHK(on, 1'b1)
		// one fault unit at full clock rate, counted edge by edge
		flt = 1'b1;
		for (i = 0; i < 90100 && on === 1'b1; i++) begin
			cyc(1);
		end
		`CHK(i > 89990 && i < 90010, 1'b1)
		flt = 1'b0;
		rchk(8'h07, 8'h20, 8'h20);
		$display("fault done");
		complete_run;
	end
endmodule
`default_nettype wire
